// file: dv/rcp_capture_test.sv
`timescale 1ns/1ps
`include "rcp_consts.svh"
module rcp_capture_test;
  import rcp_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  rcp_word_t   word;
  logic        pclk, ls, fs, fld, ls_o, ls_oe, fs_o, fs_oe;
  logic [15:0] pdat;
  int          n_fail, check_count, cyc;
  logic [31:0] got_q[$];

  rcp_capture dut_u (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_PIX_CLK(pclk),
    .I_RAW_PIXEL_DATA_IN(pdat), .I_LINE_SYNC_IN(ls), .I_FRAME_SYNC_IN(fs),
    .I_FIELD_IN(fld), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_WORD(word), .O_LINE_SYNC_OUT(ls_o), .O_LINE_SYNC_OE(ls_oe),
    .O_FRAME_SYNC_OUT(fs_o), .O_FRAME_SYNC_OE(fs_oe));
  rcp_sensor_model sensor_u (.o_pix_clk(pclk), .o_data(pdat), .o_line_sync(ls),
    .o_frame_sync(fs), .o_field(fld));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Collect words away from the launching edge; the cycle ceiling stops a hung run.
  always @(negedge clk) begin
    if (word.valid === 1'b1) got_q.push_back(word.data);
    if (cyc++ > 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [7:0] alaw(logic [9:0] x);
    for (int k = 5; k >= 1; k--) if (x[k + 4]) return {3'(k), 5'(x >> (k - 1))};
    return {3'h0, x[4:0]};
  endfunction

  // One frame of four eight-pixel lines; a 4x1 window is captured from it.
  // The tick that carries the line edge is judged on the old count, so the
  // pixel at count zero is the second one the sensor sends in a line.
  task automatic cap(logic [7:0] mode, logic f, logic [15:0] hst, vev, vod, seed, step);
    logic [15:0] v;
    logic [7:0]  b [4];
    logic [15:0] h [4];
    int          line;
    wr_reg(`RCP_OFF_MODE, {24'h0, mode});
    wr_reg(`RCP_OFF_HSTART, {16'h0, hst});
    wr_reg(`RCP_OFF_HSIZE, 32'h4);
    wr_reg(`RCP_OFF_VST_EV, {16'h0, vev});
    wr_reg(`RCP_OFF_VST_OD, {16'h0, vod});
    wr_reg(`RCP_OFF_VSIZE, 32'h1);
    line = f ? vod : vev;
    for (int i = 0; i < 4; i++) begin
      v = (seed + 16'(line * 8 + hst + 1 + i) * step) & 16'((17'h1 << (mode[7:4] + 1)) - 1);
      b[i] = mode[2] ? alaw(v[9:0]) : v[7:0];
      h[i] = mode[2] ? {8'h0, b[i]} : v;
    end
    got_q.delete();
    sensor_u.frame(f, 4, 8, seed, step);
    repeat (20) @(posedge clk);
    if (mode[3]) begin
      check("word count", 32'(got_q.size()), 32'h1);
      check("packed word", got_q[0], {b[3], b[2], b[1], b[0]});
    end else begin
      check("word count", 32'(got_q.size()), 32'h2);
      check("first word", got_q[0], {h[1], h[0]});
      check("second word", got_q[1], {h[3], h[2]});
    end
  endtask

  task automatic t_reset();
    logic [7:0]  a [6] = '{8'h00, 8'h08, 8'h14, 8'h18, 8'h1C, 8'h24};
    logic [31:0] e [6] = '{32'hF0, 32'h280, 32'h1E0, 32'h320, 32'h20D, 32'h0};
    logic [31:0] d;
    check("sync drive", {30'h0, ls_oe, fs_oe}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rd_reg(a[i], d);
      check("reset value", d, e[i]);
    end
    got_q.delete();
    sensor_u.frame(1'b0, 2, 6, 16'h1234, 16'h1);
    repeat (20) @(posedge clk);
    check("disabled words", 32'(got_q.size()), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_unpacked();
    logic [31:0] d;
    cap(8'h91, 1'b0, 16'h1, 16'h1, 16'h2, 16'hFC05, 16'h0135);
    cap(8'hF1, 1'b1, 16'h1, 16'h1, 16'h2, 16'h8001, 16'h1111);
    // Odd field seen, last line three, window left behind.
    rd_reg(`RCP_OFF_STATUS, d);
    check("status", d, 32'h00020003);
    $display("test unpacked done");
  endtask

  task automatic t_pack8();
    cap(8'h79, 1'b0, 16'h2, 16'h3, 16'h1, 16'hAB37, 16'h0059);
    // A three-pixel window leaves the top lane empty; the word must still come out.
    wr_reg(`RCP_OFF_HSIZE, 32'h3);
    wr_reg(`RCP_OFF_VST_EV, 32'h0);
    got_q.delete();
    sensor_u.frame(1'b0, 4, 8, 16'h0010, 16'h0001);
    repeat (20) @(posedge clk);
    check("flush count", 32'(got_q.size()), 32'h1);
    check("flushed word", got_q[0], 32'h00151413);
    $display("test pack8 done");
  endtask

  task automatic t_alaw();
    cap(8'h95, 1'b0, 16'h0, 16'h0, 16'h1, 16'hFC10, 16'h0070);
    cap(8'h9D, 1'b1, 16'h1, 16'h0, 16'h1, 16'hFC03, 16'h0035);
    $display("test alaw done");
  endtask

  function automatic logic pick(bit f);
    return f ? fs_o : ls_o;
  endfunction

  task automatic measure(bit f, output int hi, output int per);
    hi = 0;
    for (int n = 0; n < 2000 && pick(f) !== 1'b0; n++) @(posedge clk);
    for (int n = 0; n < 2000 && pick(f) !== 1'b1; n++) @(posedge clk);
    while (pick(f) === 1'b1 && hi < 2000) begin
      @(posedge clk);
      hi++;
    end
    per = hi;
    while (pick(f) !== 1'b1 && per < 2000) begin
      @(posedge clk);
      per++;
    end
  endtask

  // Eight system cycles per pixel, so sync widths scale by eight.
  task automatic t_int();
    int hi, per;
    wr_reg(`RCP_OFF_HPER, 32'hA);
    wr_reg(`RCP_OFF_VPER, 32'h4);
    wr_reg(`RCP_OFF_MODE, 32'hF3);
    @(posedge clk);
    #1 check("sync drive", {30'h0, ls_oe, fs_oe}, 32'h3);
    fork
      sensor_u.run(200);
    join_none
    measure(1'b0, hi, per);
    check("line high", 32'(hi), 32'd32);
    check("line period", 32'(per), 32'd80);
    measure(1'b1, hi, per);
    check("frame high", 32'(hi), 32'd160);
    check("frame period", 32'(per), 32'd320);
    wait fork;
    $display("test internal sync done");
  endtask

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_unpacked();
    t_pack8();
    t_alaw();
    t_int();
    test_done();
  end
endmodule

// file: dv/rcp_sensor_model.sv
`timescale 1ns/1ps
// Behavioural sensor: the pixel clock runs only inside frames or a free run and stands low otherwise.
module rcp_sensor_model (
  output logic        o_pix_clk,
  output logic [15:0] o_data,
  output logic        o_line_sync,
  output logic        o_frame_sync,
  output logic        o_field
);
  // Quiet pins at time zero.
  initial begin
    o_pix_clk = 1'b0;
    o_data = 16'h0;
    o_line_sync = 1'b0;
    o_frame_sync = 1'b0;
    o_field = 1'b0;
  end

  // Data and syncs change on the falling edge so they are steady at the rising one.
  task automatic tick(input logic [15:0] d, input logic ls, input logic fs);
    o_data = d;
    o_line_sync = ls;
    o_frame_sync = fs;
    #16 o_pix_clk = 1'b1;
    #16 o_pix_clk = 1'b0;
  endtask

  // Upper data lines carry seed bits, as unconnected pins would carry noise.
  task automatic frame(input logic fld, input int nl, input int np,
                       input logic [15:0] seed, input logic [15:0] step);
    #1.3;
    o_field = fld;
    for (int l = 0; l < nl; l++) begin
      for (int p = 0; p < np + 3; p++) begin
        tick(p < np ? seed + 16'(l * np + p) * step : ~o_data, p < 2, l == 0 && p < 2);
      end
    end
    o_data = ~o_data; // A released bus must not look like the last pixel.
  endtask

  // Free-running clock while the block makes its own syncs.
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      tick(~o_data, 1'b0, 1'b0);
    end
  endtask
endmodule

// file: pkg/rcp_consts.svh
`ifndef RCP_CONSTS_SVH
`define RCP_CONSTS_SVH
// Register byte offsets.
`define RCP_OFF_MODE   8'h00
`define RCP_OFF_HSTART 8'h04
`define RCP_OFF_HSIZE  8'h08
`define RCP_OFF_VST_EV 8'h0C
`define RCP_OFF_VST_OD 8'h10
`define RCP_OFF_VSIZE  8'h14
`define RCP_OFF_HPER   8'h18
`define RCP_OFF_VPER   8'h1C
`define RCP_OFF_STATUS 8'h20
// Reset values: capture off, external syncs, full 16-bit width.
`define RCP_RST_MODE   8'hF0
`define RCP_RST_HSIZE  16'h0280
`define RCP_RST_VSIZE  16'h01E0
`define RCP_RST_HPER   16'h0320
`define RCP_RST_VPER   16'h020D
// Width of generated sync pulses, in pixels and in lines.
`define RCP_HSYNC_W    16'h0004
`define RCP_VSYNC_W    16'h0002
// Positions in the synchroniser vector.
`define RCP_SYN_PCLK   19
`define RCP_SYN_LINE   18
`define RCP_SYN_FRAME  17
`define RCP_SYN_FIELD  16
`endif

// file: pkg/rcp_pkg.sv
package rcp_pkg;
  // Mode register layout, MSB first.
  typedef struct packed {
    logic [3:0] width_sel;
    logic       pack8;
    logic       alaw;
    logic       int_sync;
    logic       enable;
  } rcp_mode_t;

  // Capture geometry and generated timing.
  typedef struct packed {
    logic [15:0] hstart;
    logic [15:0] hsize;
    logic [15:0] vst_even;
    logic [15:0] vst_odd;
    logic [15:0] vsize;
    logic [15:0] hper;
    logic [15:0] vper;
  } rcp_geom_t;

  // One formatted memory word.
  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } rcp_word_t;
endpackage

// file: src/rcp_capture.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "rcp_consts.svh"
// Overview of operation
// - Raw samples of up to 16 bits are taken from the parallel pixel data input.
// - The width select marks the highest valid input bit and upper bits are ignored.
// - Line and frame syncs are either generated here or taken from outside.
// - The first captured line is programmed separately for even and odd fields.
// - Only pixels inside the programmed window are formatted and sent on.
// - Unpacked pixels sit zero-filled in halfwords, two per word, earlier one low.
// - Optional A-law compression maps 10-bit samples to 8 bits.
// - In packed mode four 8-bit pixels fill a word, earliest in the low byte.
module rcp_capture (
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_RESETN,
  input  wire logic                I_PIX_CLK,
  input  wire logic [15:0]         I_RAW_PIXEL_DATA_IN,
  input  wire logic                I_LINE_SYNC_IN,
  input  wire logic                I_FRAME_SYNC_IN,
  input  wire logic                I_FIELD_IN,
  input  wire logic [7:0]          I_ADDR,
  input  wire logic [31:0]         I_WDATA,
  input  wire logic                I_WR,
  input  wire logic                I_RD,
  output logic [31:0]              O_RDATA,
  output rcp_pkg::rcp_word_t       O_WORD,
  output logic                     O_LINE_SYNC_OUT,
  output logic                     O_LINE_SYNC_OE,
  output logic                     O_FRAME_SYNC_OUT,
  output logic                     O_FRAME_SYNC_OE
);
  import rcp_pkg::*;

  logic [19:0] meta_q, sync_q;
  logic        pclk_prev_q;
  logic        tick;
  rcp_mode_t   mode_q, mode_d;
  rcp_geom_t   geom_q, geom_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] hcnt_q, hcnt_d, vcnt_q, vcnt_d;
  logic        field_q, field_d, hs_prev_q, hs_prev_d, vs_prev_q, vs_prev_d;
  logic        lso_q, lso_d, fso_q, fso_d, oe_q, oe_d;
  logic [15:0] vst, mask, pix;
  logic [7:0]  pix8;
  logic        in_win, line_edge, frame_edge;
  logic [31:0] acc_q, acc_d;
  logic [1:0]  slot_q, slot_d;
  rcp_word_t   word_q, word_d;

  // A-law style companding: 3-bit segment and 5-bit mantissa, monotonic.
  function automatic logic [7:0] rcp_alaw(input logic [9:0] x);
    logic [7:0] r;
    r = {3'h0, x[4:0]};
    for (int k = 1; k <= 5; k++) begin
      if (x[k+4]) begin
        r = {k[2:0], 5'((x >> (k - 1)) & 10'h01F)};
      end
    end
    return r;
  endfunction

  // Every sensor-side input passes two flops; the first stage feeds only the second.
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      meta_q      <= 20'h00000;
      sync_q      <= 20'h00000;
      pclk_prev_q <= 1'b0;
    end else begin
      meta_q      <= {I_PIX_CLK, I_LINE_SYNC_IN, I_FRAME_SYNC_IN, I_FIELD_IN,
                      I_RAW_PIXEL_DATA_IN};
      sync_q      <= meta_q;
      pclk_prev_q <= sync_q[`RCP_SYN_PCLK];
    end
  end

  // Data travels through the same two stages as the clock, so they stay aligned.
  assign tick = sync_q[`RCP_SYN_PCLK] & ~pclk_prev_q;

  // Register writes and one-cycle read answers; unmapped reads give zero.
  always_comb begin
    mode_d  = mode_q;
    geom_d  = geom_q;
    rdata_d = 32'h00000000;
    if (I_WR) begin
      unique case (I_ADDR)
        `RCP_OFF_MODE:   mode_d          = I_WDATA[7:0];
        `RCP_OFF_HSTART: geom_d.hstart   = I_WDATA[15:0];
        `RCP_OFF_HSIZE:  geom_d.hsize    = I_WDATA[15:0];
        `RCP_OFF_VST_EV: geom_d.vst_even = I_WDATA[15:0];
        `RCP_OFF_VST_OD: geom_d.vst_odd  = I_WDATA[15:0];
        `RCP_OFF_VSIZE:  geom_d.vsize    = I_WDATA[15:0];
        `RCP_OFF_HPER:   geom_d.hper     = I_WDATA[15:0];
        `RCP_OFF_VPER:   geom_d.vper     = I_WDATA[15:0];
        default: ;
      endcase
    end
    if (I_RD) begin
      unique case (I_ADDR)
        `RCP_OFF_MODE:   rdata_d = {24'h000000, mode_q};
        `RCP_OFF_HSTART: rdata_d = {16'h0000, geom_q.hstart};
        `RCP_OFF_HSIZE:  rdata_d = {16'h0000, geom_q.hsize};
        `RCP_OFF_VST_EV: rdata_d = {16'h0000, geom_q.vst_even};
        `RCP_OFF_VST_OD: rdata_d = {16'h0000, geom_q.vst_odd};
        `RCP_OFF_VSIZE:  rdata_d = {16'h0000, geom_q.vsize};
        `RCP_OFF_HPER:   rdata_d = {16'h0000, geom_q.hper};
        `RCP_OFF_VPER:   rdata_d = {16'h0000, geom_q.vper};
        `RCP_OFF_STATUS: rdata_d = {14'h0000, field_q, in_win, vcnt_q};
        default:         rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mode_q  <= `RCP_RST_MODE;
      geom_q  <= {16'h0000, `RCP_RST_HSIZE, 16'h0000, 16'h0000, `RCP_RST_VSIZE,
                  `RCP_RST_HPER, `RCP_RST_VPER};
      rdata_q <= 32'h00000000;
    end else begin
      mode_q  <= mode_d;
      geom_q  <= geom_d;
      rdata_q <= rdata_d;
    end
  end

  // Sync edges are judged only on pixel ticks so glitches between ticks are ignored.
  assign line_edge  = sync_q[`RCP_SYN_LINE] & ~hs_prev_q;
  assign frame_edge = sync_q[`RCP_SYN_FRAME] & ~vs_prev_q;

  // Pixel and line counters, from outside syncs or from the generated timing.
  always_comb begin
    hcnt_d    = hcnt_q;
    vcnt_d    = vcnt_q;
    field_d   = field_q;
    hs_prev_d = hs_prev_q;
    vs_prev_d = vs_prev_q;
    lso_d     = lso_q & mode_q.int_sync; // Drop at once on a switch to outside syncs.
    fso_d     = fso_q & mode_q.int_sync;
    oe_d      = mode_q.int_sync;
    if (!mode_q.enable) begin
      hcnt_d = 16'h0000;
      vcnt_d = 16'h0000;
      lso_d  = 1'b0;
      fso_d  = 1'b0;
    end else if (tick) begin
      hs_prev_d = sync_q[`RCP_SYN_LINE];
      vs_prev_d = sync_q[`RCP_SYN_FRAME];
      if (mode_q.int_sync) begin
        // Generated timing: fixed periods, field flips every frame.
        if (hcnt_q >= geom_q.hper - 16'h0001) begin
          hcnt_d = 16'h0000;
          if (vcnt_q >= geom_q.vper - 16'h0001) begin
            vcnt_d  = 16'h0000;
            field_d = ~field_q;
          end else begin
            vcnt_d = vcnt_q + 16'h0001;
          end
        end else begin
          hcnt_d = hcnt_q + 16'h0001;
        end
        lso_d = hcnt_d < `RCP_HSYNC_W;
        fso_d = vcnt_d < `RCP_VSYNC_W;
      end else begin
        // Outside syncs: rising edges restart the counts, frame edge wins.
        if (hcnt_q != 16'hFFFF) begin
          hcnt_d = hcnt_q + 16'h0001;
        end
        if (line_edge) begin
          hcnt_d = 16'h0000;
          vcnt_d = vcnt_q + 16'h0001;
        end
        if (frame_edge) begin
          vcnt_d  = 16'h0000;
          field_d = sync_q[`RCP_SYN_FIELD];
        end
        lso_d = 1'b0;
        fso_d = 1'b0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hcnt_q    <= 16'h0000;
      vcnt_q    <= 16'h0000;
      field_q   <= 1'b0;
      hs_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
      lso_q     <= 1'b0;
      fso_q     <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      hcnt_q    <= hcnt_d;
      vcnt_q    <= vcnt_d;
      field_q   <= field_d;
      hs_prev_q <= hs_prev_d;
      vs_prev_q <= vs_prev_d;
      lso_q     <= lso_d;
      fso_q     <= fso_d;
      oe_q      <= oe_d;
    end
  end

  // Window test and sample shaping.
  assign vst    = field_q ? geom_q.vst_odd : geom_q.vst_even;
  assign in_win = mode_q.enable
               && ({1'b0, hcnt_q} >= {1'b0, geom_q.hstart})
               && ({1'b0, hcnt_q} < {1'b0, geom_q.hstart} + {1'b0, geom_q.hsize})
               && ({1'b0, vcnt_q} >= {1'b0, vst})
               && ({1'b0, vcnt_q} < {1'b0, vst} + {1'b0, geom_q.vsize});
  assign mask   = 16'hFFFF >> (4'hF - mode_q.width_sel);
  assign pix    = sync_q[15:0] & mask;
  assign pix8   = mode_q.alaw ? rcp_alaw(pix[9:0]) : pix[7:0];

  // Word packer; a partial word is flushed when a line leaves the window.
  always_comb begin
    acc_d  = acc_q;
    slot_d = slot_q;
    word_d = '0;
    if (tick && in_win) begin
      if (mode_q.pack8) begin
        acc_d[8*slot_q +: 8] = pix8;
        slot_d = slot_q + 2'h1;
        if (slot_q == 2'h3) begin
          word_d = '{data: acc_d, valid: 1'b1};
          acc_d  = 32'h00000000;
        end
      end else begin
        acc_d[16*slot_q[0] +: 16] = mode_q.alaw ? {8'h00, pix8} : pix;
        slot_d = {1'b0, ~slot_q[0]};
        if (slot_q[0]) begin
          word_d = '{data: acc_d, valid: 1'b1};
          acc_d  = 32'h00000000;
        end
      end
    end else if (tick && slot_q != 2'h0) begin
      word_d = '{data: acc_q, valid: 1'b1};
      acc_d  = 32'h00000000;
      slot_d = 2'h0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      acc_q  <= 32'h00000000;
      slot_q <= 2'h0;
      word_q <= '0;
    end else begin
      acc_q  <= acc_d;
      slot_q <= slot_d;
      word_q <= word_d;
    end
  end

  assign O_RDATA          = rdata_q;
  assign O_WORD           = word_q;
  assign O_LINE_SYNC_OUT  = lso_q;
  assign O_FRAME_SYNC_OUT = fso_q;
  assign O_LINE_SYNC_OE   = oe_q;
  assign O_FRAME_SYNC_OE  = oe_q;

  // Checks on the block's outputs and internal state.
  AST_WORD_AFTER_TICK: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    word_q.valid |-> $past(tick)) else $error("Word emitted without a pixel tick.");
  AST_WORD_ONE_CYCLE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    word_q.valid |=> !word_q.valid [*2]) else $error("Word valid longer than one cycle.");
  AST_MASK_UPPER: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    tick |-> (pix & ~mask) == 16'h0000 && (pix >> mode_q.width_sel) <= 16'h0001)
    else $error("Bits above the selected width leaked.");
  AST_HALF_PAIR: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    tick && in_win && !mode_q.pack8 && slot_q == 2'h1 && !mode_q.alaw
    |=> word_q.valid && word_q.data[31:16] == $past(pix))
    else $error("Second pixel not in upper halfword.");
  AST_ALAW_ZERO: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    word_q.valid && $past(mode_q.alaw && !mode_q.pack8 && in_win)
    |-> word_q.data[31:24] == 8'h00 && word_q.data[15:8] == 8'h00)
    else $error("Compressed pixel wider than 8 bits.");
  AST_PACK_FOURTH: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    tick && in_win && mode_q.pack8 && slot_q == 2'h3
    |=> word_q.valid && word_q.data[31:24] == $past(pix8))
    else $error("Fourth byte not in the top lane.");
  AST_SYNC_OE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    ##1 O_LINE_SYNC_OE == $past(mode_q.int_sync) && (O_LINE_SYNC_OE || !O_LINE_SYNC_OUT))
    else $error("Sync drive does not follow the mode.");
  AST_EXT_LINE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    mode_q.enable && !mode_q.int_sync && tick && line_edge && !frame_edge
    |=> hcnt_q == 16'h0000 && vcnt_q == $past(vcnt_q) + 16'h0001)
    else $error("Outside line sync did not restart the line.");
  AST_FIELD_START: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    in_win |-> vcnt_q >= (field_q ? geom_q.vst_odd : geom_q.vst_even))
    else $error("Capture began above the field start line.");
  COV_PACK8: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    word_q.valid && mode_q.pack8);
  COV_ALAW: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    word_q.valid && mode_q.alaw);
  COV_FRAME_EDGE: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    tick && frame_edge && !mode_q.int_sync);
  COV_FLUSH: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    tick && !in_win && slot_q != 2'h0);
endmodule
